// File: lsr_regs.sv
// electrode status and breathing control registers on an axi4-lite slave
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module lsr_regs
  import lsr_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)(
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // lead-off detector side
  input  wire logic [4:0]        loff_comp_in,
  input  wire logic [4:0]        electrode_sense_select_in,
  input  wire logic              conv_done_in,
  // breathing external step
  input  wire logic              breathing_ext_tick_in,
  // analog controls
  output logic                   mod_clk_out,
  output logic                   breathing_mod_out,
  output logic                   breathing_demod_out,
  output logic                   offset_cal_enable_out,
  output logic                   leg_drive_ref_internal_out,
  // interrupt
  output logic                   irq_out
);

  if (ADDR_W < 8)
  begin : g_bad_addr
    $error("lsr_regs: ADDR_W must be at least 8");
  end

  // bus state
  logic       aw_full_q;
  logic [5:0] aw_idx_q;
  logic       aw_map_q;
  logic       w_full_q;
  logic [7:0] wdata_q;
  logic       wstrb_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  logic       rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // register state
  logic [4:0] stat_q;
  logic [4:0] stat_d;
  logic [1:0] div_q;
  logic [7:0] resp_ctl_q;
  logic [7:0] resp_frq_q;
  logic [4:0] ist_q;
  logic [4:0] ist_d;
  logic [4:0] imask_q;
  logic       irq_q;

  // decode wires
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_wr;
  logic        wr_en;
  logic        wr_stat;
  logic        wr_ctl;
  logic        wr_frq;
  logic        wr_istat;
  logic        wr_imask;
  logic [5:0]  aw_idx;
  logic        aw_map;
  logic [5:0]  ar_idx;
  logic        ar_hi_ok;
  logic        ar_map;
  logic [31:0] rd_word;
  logic [4:0]  ev;
  logic [4:0]  clr;
  logic        mod_tick;

  // handshakes: one write and one read held at a time
  assign s_axi_awready_out = ~aw_full_q;
  assign s_axi_wready_out  = ~w_full_q;
  assign s_axi_arready_out = ~rvalid_q;
  assign aw_take  = s_axi_awvalid_in & ~aw_full_q;
  assign w_take   = s_axi_wvalid_in & ~w_full_q;
  assign ar_take  = s_axi_arvalid_in & ~rvalid_q;
  // write fires once address and data both held and no response pending
  assign do_wr    = aw_full_q & w_full_q & ~bvalid_q;
  assign wr_en    = do_wr & aw_map_q & wstrb_q;

  // address decode, upper address bits must be zero
  assign aw_idx   = s_axi_awaddr_in[7:2];
  assign aw_map   = ((s_axi_awaddr_in >> 8) == '0) &&
                    (aw_idx == IDX_STATUS || aw_idx == IDX_RESP_CTL ||
                     aw_idx == IDX_RESP_FRQ || aw_idx == IDX_IRQ_STAT ||
                     aw_idx == IDX_IRQ_MASK);
  assign ar_idx   = s_axi_araddr_in[7:2];
  assign ar_hi_ok = (s_axi_araddr_in >> 8) == '0;
  assign ar_map   = ar_hi_ok &&
                    (ar_idx == IDX_STATUS || ar_idx == IDX_RESP_CTL ||
                     ar_idx == IDX_RESP_FRQ || ar_idx == IDX_IRQ_STAT ||
                     ar_idx == IDX_IRQ_MASK);
  assign wr_stat  = wr_en & (aw_idx_q == IDX_STATUS);
  assign wr_ctl   = wr_en & (aw_idx_q == IDX_RESP_CTL);
  assign wr_frq   = wr_en & (aw_idx_q == IDX_RESP_FRQ);
  assign wr_istat = wr_en & (aw_idx_q == IDX_IRQ_STAT);
  assign wr_imask = wr_en & (aw_idx_q == IDX_IRQ_MASK);

  // read mux; bit 7 of the status register always reads zero
  assign rd_word  =
    !ar_map                   ? 32'h0000_0000 :
    (ar_idx == IDX_STATUS)    ? {24'h00_0000, 1'b0, div_q, stat_q} :
    (ar_idx == IDX_RESP_CTL)  ? {24'h00_0000, resp_ctl_q} :
    (ar_idx == IDX_RESP_FRQ)  ? {24'h00_0000, resp_frq_q} :
    (ar_idx == IDX_IRQ_STAT)  ? {27'h000_0000, ist_q} :
                                {27'h000_0000, imask_q};

  // detach events, only for electrodes whose sensing is enabled
  assign ev  = {5{conv_done_in}} & loff_comp_in & ~stat_q
               & electrode_sense_select_in;
  assign clr = {5{wr_istat}} & wdata_q[4:0];

  // per electrode: flag follows comparator, sticky event bit, set wins
  for (genvar i = 0; i < NUM_ELEC; i++)
  begin : g_elec
    assign stat_d[i] = conv_done_in ? loff_comp_in[i] : stat_q[i];
    assign ist_d[i]  = ev[i] | (ist_q[i] & ~clr[i]);
  end

  // write channel capture
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      aw_full_q <= 1'b0;
      aw_idx_q  <= 6'h00;
      aw_map_q  <= 1'b0;
      w_full_q  <= 1'b0;
      wdata_q   <= 8'h00;
      wstrb_q   <= 1'b0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full_q <= 1'b1;
        aw_idx_q  <= aw_idx;
        aw_map_q  <= aw_map;
      end
      else if (do_wr)
        aw_full_q <= 1'b0;
      if (w_take)
      begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata_in[7:0];
        wstrb_q  <= s_axi_wstrb_in[0];
      end
      else if (do_wr)
        w_full_q <= 1'b0;
    end
  end

  // write response; unmapped address answers slverr
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= aw_map_q ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready_in)
      bvalid_q <= 1'b0;
  end

  // read response, data held until taken
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= ar_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready_in)
      rvalid_q <= 1'b0;
  end

  // status flags and events; flag writes are ignored on purpose
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      stat_q <= STAT_RST;
      ist_q  <= 5'h00;
      irq_q  <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      ist_q  <= ist_d;
      irq_q  <= |(ist_q & imask_q);
    end
  end

  // software controls; fixed bits stored as written
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      div_q      <= DIV_RST;
      resp_ctl_q <= RESP_CTL_RST;
      resp_frq_q <= RESP_FRQ_RST;
      imask_q    <= MASK_RST;
    end
    else
    begin
      if (wr_stat)
        div_q <= wdata_q[DIV_LSB +: 2];
      if (wr_ctl)
        resp_ctl_q <= wdata_q;
      if (wr_frq)
        resp_frq_q <= wdata_q;
      if (wr_imask)
        imask_q <= wdata_q[4:0];
    end
  end

  // modulator clock divider
  lsr_clk_div #(
    .CNT_W (4)
  ) u_div (
    .sys_clk_in   (sys_clk_in),
    .sys_rst_in   (sys_rst_in),
    .div_sel_in   (div_q),
    .mod_clk_out  (mod_clk_out),
    .mod_tick_out (mod_tick)
  );

  // breathing control, internal step from the modulator tick
  lsr_resp_phase u_phase (
    .sys_clk_in  (sys_clk_in),
    .sys_rst_in  (sys_rst_in),
    .int_tick_in (mod_tick),
    .ext_tick_in (breathing_ext_tick_in),
    .clk_src_in  (resp_ctl_q[BIT_CLKSRC]),
    .freq_sel_in (resp_frq_q[BIT_FRQSEL]),
    .phase_in    (resp_ctl_q[PH_LSB +: 4]),
    .mod_en_in   (resp_ctl_q[BIT_MOD]),
    .demod_en_in (resp_ctl_q[BIT_DEMOD]),
    .mod_out     (breathing_mod_out),
    .demod_out   (breathing_demod_out)
  );

  // outputs
  assign s_axi_bvalid_out           = bvalid_q;
  assign s_axi_bresp_out            = bresp_q;
  assign s_axi_rvalid_out           = rvalid_q;
  assign s_axi_rdata_out            = rdata_q;
  assign s_axi_rresp_out            = rresp_q;
  assign offset_cal_enable_out      = resp_frq_q[BIT_CAL];
  assign leg_drive_ref_internal_out = resp_frq_q[BIT_REFINT];
  assign irq_out                    = irq_q;

  property p_stat_reset;
    @(posedge sys_clk_in)
    sys_rst_in |=> stat_q == STAT_RST;
  endproperty
  a_stat_reset: assert property (p_stat_reset)
    else $error("electrode flags not clear after reset");

  property p_ch1_flags;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    conv_done_in |=> stat_q[1:0] == $past(loff_comp_in[1:0]);
  endproperty
  a_ch1_flags: assert property (p_ch1_flags)
    else $error("channel 1 flags not taken from comparators");

  property p_ch2_flags;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    conv_done_in |=> stat_q[3:2] == $past(loff_comp_in[3:2]);
  endproperty
  a_ch2_flags: assert property (p_ch2_flags)
    else $error("channel 2 flags not taken from comparators");

  property p_leg_flag;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    conv_done_in |=> stat_q[BIT_LEGDRV] == $past(loff_comp_in[4]);
  endproperty
  a_leg_flag: assert property (p_leg_flag)
    else $error("leg-drive flag not taken from comparator");

  property p_flags_hold;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !conv_done_in |=> $stable(stat_q);
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("electrode flags changed without a conversion");

  property p_stat_read;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (ar_take && ar_map && ar_idx == IDX_STATUS)
      |=> s_axi_rdata_out[31:7] == '0
          && s_axi_rdata_out[6:5] == $past(div_q);
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status read shows wrong divider or upper bits");

  property p_cal_write;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    wr_frq |=> offset_cal_enable_out == $past(wdata_q[BIT_CAL]);
  endproperty
  a_cal_write: assert property (p_cal_write)
    else $error("calibration enable did not follow write");

  property p_ref_write;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    wr_frq |=> leg_drive_ref_internal_out == $past(wdata_q[BIT_REFINT]);
  endproperty
  a_ref_write: assert property (p_ref_write)
    else $error("reference select did not follow write");

  property p_set_wins;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (ev != 5'h00) |=> ((ist_q & $past(ev)) == $past(ev));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against a clear");

endmodule // lsr_regs

// File: lsr_pkg.sv
// package: register indices, field positions, reset values for the block
package lsr_pkg;

  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_STATUS   = 6'h08;
  localparam logic [5:0] IDX_RESP_CTL = 6'h09;
  localparam logic [5:0] IDX_RESP_FRQ = 6'h0A;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h11;

  // electrode status register fields
  localparam int unsigned NUM_ELEC    = 5;
  localparam int unsigned BIT_C1P     = 0;
  localparam int unsigned BIT_C1N     = 1;
  localparam int unsigned BIT_C2P     = 2;
  localparam int unsigned BIT_C2N     = 3;
  localparam int unsigned BIT_LEGDRV  = 4;
  localparam int unsigned DIV_LSB     = 5;

  // breathing control fields
  localparam int unsigned BIT_DEMOD   = 7;
  localparam int unsigned BIT_MOD     = 6;
  localparam int unsigned PH_LSB      = 2;
  localparam int unsigned BIT_CLKSRC  = 0;

  // breathing frequency control fields
  localparam int unsigned BIT_CAL     = 7;
  localparam int unsigned BIT_FRQSEL  = 2;
  localparam int unsigned BIT_REFINT  = 1;

  // reset values
  localparam logic [4:0] STAT_RST     = 5'h00;
  localparam logic [1:0] DIV_RST      = 2'h0;
  localparam logic [7:0] RESP_CTL_RST = 8'h02;
  localparam logic [7:0] RESP_FRQ_RST = 8'h03;
  localparam logic [4:0] MASK_RST     = 5'h00;

  // modulator divider codes
  localparam logic [1:0] DIV_BY4      = 2'h0;
  localparam logic [1:0] DIV_BY8      = 2'h1;
  localparam logic [1:0] DIV_BY16     = 2'h2;

  // bus responses
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // phase counter width, giving 32 steps per control period
  localparam int unsigned PH_CNT_W    = 5;

endpackage

// File: lsr_clk_div.sv
// modulator clock divider: square wave and one-cycle tick
`timescale 1ns/1ps
module lsr_clk_div
  import lsr_pkg::*;
#(
  parameter int unsigned CNT_W = 4
)(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  // divider code
  input  wire logic [1:0] div_sel_in,
  // divided outputs
  output logic            mod_clk_out,
  output logic            mod_tick_out
);

  if (CNT_W < 4)
  begin : g_bad_width
    $error("lsr_clk_div: CNT_W must be at least 4");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] mask;
  logic [CNT_W-1:0] top;
  logic             mod_clk_q;
  logic             tick_q;

  // reserved code gives an empty mask, which stops the clock low
  assign mask = (div_sel_in == DIV_BY4)  ? CNT_W'(4'h3) :
                (div_sel_in == DIV_BY8)  ? CNT_W'(4'h7) :
                (div_sel_in == DIV_BY16) ? CNT_W'(4'hF) : '0;
  assign top  = mask ^ (mask >> 1);

  // free-running counter, divided bit sampled into a flop
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      cnt_q     <= '0;
      mod_clk_q <= 1'b0;
      tick_q    <= 1'b0;
    end
    else
    begin
      cnt_q     <= cnt_q + CNT_W'(1);
      mod_clk_q <= |(cnt_q & top);
      tick_q    <= (mask != '0) && ((cnt_q & mask) == mask);
    end
  end

  assign mod_clk_out  = mod_clk_q;
  assign mod_tick_out = tick_q;

  // divide by four: high two cycles then low; the code must stand on
  // both sides of the rise, a change of code may leave a short pulse
  property p_div4_shape;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    ($rose(mod_clk_out) && div_sel_in == DIV_BY4
      && $past(div_sel_in) == DIV_BY4
      && $past(div_sel_in, 2) == DIV_BY4)
      ##1 (div_sel_in == DIV_BY4)
      |-> mod_clk_out ##1 !mod_clk_out;
  endproperty
  a_div4_shape: assert property (p_div4_shape)
    else $error("modulator clock not divided by four");

endmodule // lsr_clk_div

// File: lsr_resp_phase.sv
// breathing modulation and phase-shifted demodulation control
`timescale 1ns/1ps
module lsr_resp_phase
  import lsr_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  // step sources
  input  wire logic       int_tick_in,
  input  wire logic       ext_tick_in,
  // settings
  input  wire logic       clk_src_in,
  input  wire logic       freq_sel_in,
  input  wire logic [3:0] phase_in,
  input  wire logic       mod_en_in,
  input  wire logic       demod_en_in,
  // control signals
  output logic            mod_out,
  output logic            demod_out
);

  logic [PH_CNT_W-1:0] cnt_q;
  logic [PH_CNT_W-1:0] shift;
  logic [PH_CNT_W-1:0] diff;
  logic                tick;
  logic                fast;
  logic                mod_q;
  logic                demod_q;

  // frequency choice only counts with the internal clock
  assign tick  = clk_src_in ? ext_tick_in : int_tick_in;
  assign fast  = ~clk_src_in & freq_sel_in;
  // 32 steps per period at 11.25 degrees each, 16 of 22.5 degrees when fast; top phase bit dropped fast
  assign shift = fast ? {1'b0, phase_in[2:0], 1'b0}
                      : {1'b0, phase_in};
  assign diff  = cnt_q - shift;

  // phase counter and gated outputs
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      cnt_q   <= '0;
      mod_q   <= 1'b0;
      demod_q <= 1'b0;
    end
    else
    begin
      if (tick)
        cnt_q <= cnt_q + (fast ? PH_CNT_W'(2) : PH_CNT_W'(1));
      mod_q   <= mod_en_in & cnt_q[PH_CNT_W-1];
      demod_q <= demod_en_in & diff[PH_CNT_W-1];
    end
  end

  assign mod_out   = mod_q;
  assign demod_out = demod_q;

  property p_demod_off;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !demod_en_in [*2] |-> !demod_out;
  endproperty
  a_demod_off: assert property (p_demod_off)
    else $error("demodulation active while disabled");

  property p_mod_off;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !mod_en_in [*2] |-> !mod_out;
  endproperty
  a_mod_off: assert property (p_mod_off)
    else $error("modulation active while disabled");

endmodule // lsr_resp_phase

// File: leadoff_status_breathing_clock_source_regs_tb_top.sv
// self-checking bench for the electrode status and breathing registers
`timescale 1ns/1ps
module leadoff_status_breathing_clock_source_regs_tb_top;
  import lsr_pkg::*;

  typedef struct {string nm; logic [33:0] ex;} lsr_note_t;
  localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};
  localparam logic [7:0] A_CT = {IDX_RESP_CTL, 2'b00};
  localparam logic [7:0] A_FQ = {IDX_RESP_FRQ, 2'b00};
  localparam logic [7:0] A_IS = {IDX_IRQ_STAT, 2'b00};
  localparam logic [7:0] A_IM = {IDX_IRQ_MASK, 2'b00};
  // stimulus
  logic        clk, rst, awv, wv, bre, arv, rre, conv, xt, xen;
  logic [7:0]  awa, ara;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [4:0]  comp, sens;
  // observed
  logic        awr, wrd, bv, arr, rv, mclk, bmod, bdem, cal, rint, irq;
  logic [1:0]  br, rr;
  logic [31:0] rdat;
  // expected bus answers and tallies
  lsr_note_t   bq[$], rq[$];
  int          err_count, compares, xc;

  lsr_regs dut (
    .sys_clk_in(clk), .sys_rst_in(rst),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrd), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bre), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .loff_comp_in(comp),
    .electrode_sense_select_in(sens), .conv_done_in(conv),
    .breathing_ext_tick_in(xt), .mod_clk_out(mclk),
    .breathing_mod_out(bmod), .breathing_demod_out(bdem),
    .offset_cal_enable_out(cal), .leg_drive_ref_internal_out(rint),
    .irq_out(irq)
  );

  // clock, 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // external step pulse every third cycle while enabled
  always @(posedge clk)
  begin
    xc <= (xc == 2) ? 0 : xc + 1;
    xt <= xen && (xc == 2);
  end

  task automatic chk(input string nm, input logic [33:0] s, e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask

  // watcher: each bus answer is matched against the oldest note
  always @(posedge clk)
  begin
    lsr_note_t m;
    if (bv && bre && bq.size() > 0)
    begin
      m = bq.pop_front();
      chk(m.nm, {32'h0, br}, m.ex);
    end
    if (rv && rre && rq.size() > 0)
    begin
      m = rq.pop_front();
      chk(m.nm, {rr, rdat}, m.ex);
    end
  end

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] e = RESP_OKAY,
                    input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    bq.push_back('{$sformatf("bresp at %h", a), {32'h0, e}});
    awa <= a;
    wd <= {24'h0, d};
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
    end while (!(bv && bre) && n < 100);
    bre <= 1'b0;
    if (n >= 100) chk("write handshake", 1, 0);
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input string nm, input logic [1:0] e = RESP_OKAY);
    int n;
    n = 0;
    rq.push_back('{nm, {e, 24'h0, d}});
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (!(rv && rre) && n < 100);
    rre <= 1'b0;
    if (n >= 100) chk("read handshake", 1, 0);
    @(posedge clk);
  endtask

  // one conversion: comparator levels sampled by a one-cycle pulse
  task automatic cnv(input logic [4:0] c, input logic [4:0] s);
    comp <= c;
    sens <= s;
    conv <= 1'b1;
    @(posedge clk);
    conv <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  function automatic logic pk(input int s);
    case (s)
      0: return mclk;
      1: return bmod;
      2: return bdem;
      3: return cal;
      4: return rint;
      default: return irq;
    endcase
  endfunction

  // cycles from a rise of one output to the next rise of another;
  // waits out one full period first so enable transients are skipped
  task automatic gap(input int sa, input int sb, output int r);
    int n, f;
    logic pa, pb;
    n = 0;
    f = -1;
    r = -1;
    repeat (150) @(negedge clk);
    pa = pk(sa);
    pb = pk(sb);
    while (r < 0 && n < 1000)
    begin
      @(negedge clk);
      n++;
      if (f < 0 && !pa && pk(sa)) f = n;
      if (f >= 0 && !pb && pk(sb) && (n > f || sa != sb)) r = n - f;
      pa = pk(sa);
      pb = pk(sb);
    end
    @(posedge clk);
  endtask

  // counts cycles in which an output is not low
  task automatic low(input int s, output int h);
    h = 0;
    repeat (300)
    begin
      @(negedge clk);
      if (pk(s) !== 1'b0) h++;
    end
    @(posedge clk);
  endtask

  task automatic ob(input string nm, input int s, input logic e);
    @(negedge clk);
    chk(nm, pk(s), e);
    @(posedge clk);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    int p;
    int phs[3];
    logic [4:0] c;
    logic [7:0] v;
    phs = '{0, 5, 15};
    // reset high, every request and the external step low
    {rst, awv, wv, bre, arv, rre, conv, xen} = 8'h80;
    {awa, ara, wd, ws, comp, sens} = '0;
    void'($urandom(4826));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(A_ST, 8'h00, "status reset");
    rd(A_CT, 8'h02, "breathing ctl reset");
    rd(A_FQ, 8'h03, "freq ctl reset");
    rd(A_IS, 8'h00, "irq status reset");
    rd(A_IM, 8'h00, "irq mask reset");
    ob("cal reset", 3, 1'b0);
    ob("ref reset", 4, 1'b1);
    $display("test reset done");
    // one flag at a time, then random levels; flags track each conversion
    for (int i = 0; i < 10; i++)
    begin
      c = (i < 5) ? 5'(1 << i) : 5'($urandom);
      cnv(c, 5'($urandom));
      rd(A_ST, {3'b000, c}, "status flags");
    end
    wr(A_ST, 8'h7F);
    rd(A_ST, {3'b011, c}, "status after write");
    wr(A_ST, 8'h00);
    $display("test flags done");
    for (int k = 0; k < 3; k++)
    begin
      wr(A_ST, 8'(k << 5));
      gap(0, 0, p);
      chk("mod_clk period", p, 4 << k);
    end
    wr(A_ST, 8'h60);
    low(0, p);
    chk("mod_clk reserved", p, 0);
    wr(A_ST, 8'h00);
    $display("test divider done");
    low(1, p);
    chk("mod while off", p, 0);
    wr(A_CT, 8'h42);
    low(2, p);
    chk("demod while off", p, 0);
    for (int k = 0; k < 3; k++)
    begin
      v = 8'hC2 | 8'(phs[k] << 2);
      wr(A_CT, v);
      rd(A_CT, v, "ctl readback");
      gap(1, 1, p);
      chk("mod period", p, 128);
      gap(1, 2, p);
      chk("demod lag", p, 4 * phs[k]);
    end
    wr(A_FQ, 8'h07);
    wr(A_CT, 8'hF6);
    gap(1, 1, p);
    chk("mod period fast", p, 64);
    gap(1, 2, p);
    chk("demod lag fast", p, 20);
    wr(A_FQ, 8'h03);
    wr(A_CT, 8'hC3);
    xen <= 1'b1;
    gap(1, 1, p);
    chk("mod period external", p, 96);
    xen <= 1'b0;
    wr(A_CT, 8'h02);
    $display("test breathing done");
    wr(A_FQ, 8'h81);
    rd(A_FQ, 8'h81, "freq readback");
    ob("cal on", 3, 1'b1);
    ob("ref external", 4, 1'b0);
    wr(A_FQ, 8'h03);
    ob("cal off", 3, 1'b0);
    ob("ref internal", 4, 1'b1);
    $display("test frequency done");
    cnv(5'h00, 5'h1F);
    wr(A_IS, 8'h1F);
    wr(A_IM, 8'h1F);
    ob("irq idle", 5, 1'b0);
    cnv(5'h05, 5'h04);
    rd(A_IS, 8'h04, "irq events");
    ob("irq raised", 5, 1'b1);
    wr(A_IM, 8'h1B);
    ob("irq masked", 5, 1'b0);
    wr(A_IM, 8'h1F);
    ob("irq unmasked", 5, 1'b1);
    wr(A_IS, 8'h04);
    ob("irq cleared", 5, 1'b0);
    rd(A_IS, 8'h00, "irq status cleared");
    $display("test interrupt done");
    rd(8'h30, 8'h00, "unmapped read", RESP_SLVERR);
    wr(8'h30, 8'h55, RESP_SLVERR);
    wr(A_CT, 8'hFF, RESP_OKAY, 4'h0);
    rd(A_CT, 8'h02, "no strobe");
    repeat (6)
    begin
      v = 8'($urandom) | 8'h02;
      wr(A_CT, v);
      rd(A_CT, v, "ctl random");
    end
    $display("test bus done");
    complete_run();
  end

  // watchdog, well beyond the expected run length
  initial
  begin
    repeat (30000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule // leadoff_status_breathing_clock_source_regs_tb_top
